// File: hdl/bcf_mailbox_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module bcf_mailbox_fifo
  import bcf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Shared configuration
  input wire logic i_odd_parity,
  input wire logic [1:0] i_offset_preset_select,
  // Port A control
  input wire logic i_port_a_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_qualify,
  input wire logic i_port_a_write,
  input wire logic i_port_a_mailbox_select,
  input wire logic i_port_a_parity_gen,
  // Port A data bus
  input wire bcf_word_t i_port_a_data_bus,
  output bcf_word_t o_port_a_data_bus,
  output logic o_port_a_data_bus_oe,
  // Port A flags
  output logic o_port_a_empty_n,
  output logic o_port_a_almost_empty_n,
  output logic o_port_a_full_n,
  output logic o_port_a_almost_full_n,
  output logic o_port_a_parity_error_n,
  output logic o_mail_ab_pending_n,
  // Port B control
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_qualify,
  input wire logic i_port_b_write,
  input wire logic i_port_b_mailbox_select,
  input wire logic i_port_b_parity_gen,
  // Port B data bus
  input wire bcf_word_t i_port_b_data_bus,
  output bcf_word_t o_port_b_data_bus,
  output logic o_port_b_data_bus_oe,
  // Port B flags
  output logic o_port_b_empty_n,
  output logic o_port_b_almost_empty_n,
  output logic o_port_b_full_n,
  output logic o_port_b_almost_full_n,
  output logic o_port_b_parity_error_n,
  output logic o_mail_ba_pending_n
);
  // ---------------------------------------------------------------
  // Pin gathering, index 0 is port A, 1 is port B
  // ---------------------------------------------------------------
  wire logic [BCF_C_W-1:0] pin_ctl [2];
  wire bcf_word_t pin_data [2];
  wire logic [1:0] tick;
  wire logic [1:0] wr_fifo;
  wire logic [1:0] rd_fifo;
  wire logic [1:0] wr_mail;
  wire logic [1:0] rd_mail;
  wire logic [1:0] mail_flag;
  wire logic [1:0] drive;
  wire logic [1:0] perr_n;
  wire logic [1:0] st_empty_n;
  wire logic [1:0] st_aempty_n;
  wire logic [1:0] st_full_n;
  wire logic [1:0] st_afull_n;
  wire bcf_word_t in_word [2];
  wire bcf_word_t mail_word [2];
  wire bcf_word_t st_rd_data [2];
  wire bcf_word_t out_data [2];

  assign pin_ctl[0] = {i_port_a_parity_gen, i_port_a_mailbox_select, i_port_a_write,
                       i_port_a_qualify, i_port_a_select_n, i_port_a_clock};
  assign pin_ctl[1] = {i_port_b_parity_gen, i_port_b_mailbox_select, i_port_b_write,
                       i_port_b_qualify, i_port_b_select_n, i_port_b_clock};
  assign pin_data[0] = i_port_a_data_bus;
  assign pin_data[1] = i_port_b_data_bus;

  // ---------------------------------------------------------------
  // Shared configuration
  // ---------------------------------------------------------------
  logic odd_s1_q;
  logic odd_s2_q;
  logic [1:0] fs_s1_q;
  logic [1:0] fs_s2_q;
  logic offset_armed_q;
  bcf_count_t offset_q;

  // Synchronisers carry no reset so the straps are valid at release
  always_ff @(posedge i_clk) begin
    odd_s1_q <= i_odd_parity;
    odd_s2_q <= odd_s1_q;
    fs_s1_q <= i_offset_preset_select;
    fs_s2_q <= fs_s1_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      offset_armed_q <= 1'b1;
      offset_q <= BCF_OFFSET_RST;
    end else if (offset_armed_q) begin
      offset_armed_q <= 1'b0;
      offset_q <= BCF_OFFSET_PRESETS[fs_s2_q];
    end
  end

  // ---------------------------------------------------------------
  // Per-port logic
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      localparam int Q = 1 - p;
      logic [BCF_C_W-1:0] ctl_s1_q;
      logic [BCF_C_W-1:0] ctl_s2_q;
      bcf_word_t data_s1_q;
      bcf_word_t data_s2_q;
      logic clk_prev_q;
      bcf_word_t mail_q;
      logic mail_flag_q;
      bcf_word_t dout_q;
      logic oe_q;
      logic perr_n_q;
      wire logic op;
      wire logic [BCF_LANES-1:0] lane_ok;
      wire bcf_word_t sel_word;
      wire bcf_word_t gen_word;
      wire logic gen_on_mail;

      // port clock sampled as a plain input, so both clocks may be unrelated
      always_ff @(posedge i_clk) begin
        ctl_s1_q <= pin_ctl[p];
        ctl_s2_q <= ctl_s1_q;
        data_s1_q <= pin_data[p];
        data_s2_q <= data_s1_q;
      end

      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          clk_prev_q <= 1'b0;
        end else begin
          clk_prev_q <= ctl_s2_q[BCF_C_CLK];
        end
      end

      assign tick[p] = ctl_s2_q[BCF_C_CLK] & ~clk_prev_q;
      assign op = tick[p] & ~ctl_s2_q[BCF_C_SEL_N] & ctl_s2_q[BCF_C_QUAL];
      assign wr_fifo[p] = op & ctl_s2_q[BCF_C_WRITE] & ~ctl_s2_q[BCF_C_MBOX];
      assign rd_fifo[p] = op & ~ctl_s2_q[BCF_C_WRITE] & ~ctl_s2_q[BCF_C_MBOX];
      assign wr_mail[p] = op & ctl_s2_q[BCF_C_WRITE] & ctl_s2_q[BCF_C_MBOX];
      assign rd_mail[p] = op & ~ctl_s2_q[BCF_C_WRITE] & ctl_s2_q[BCF_C_MBOX];
      assign in_word[p] = data_s2_q;

      // mailbox and its flag
      // A pending mailbox refuses new writes; an accepted write wins over a same-cycle mailbox read by the other port
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          mail_q <= BCF_WORD_RST;
          mail_flag_q <= BCF_MAIL_FLAG_RST;
        end else if (wr_mail[p] & mail_flag_q) begin
          mail_q <= data_s2_q;
          mail_flag_q <= 1'b0;
        end else if (rd_mail[Q]) begin
          mail_flag_q <= 1'b1;
        end
      end
      assign mail_word[p] = mail_q;
      assign mail_flag[p] = mail_flag_q;

      // parity check and generation per lane
      assign sel_word = ctl_s2_q[BCF_C_MBOX] ? mail_word[Q] : st_rd_data[Q];
      genvar l;
      for (l = 0; l < BCF_LANES; l++) begin : g_lane
        localparam int LO = l * BCF_LANE_W;
        assign lane_ok[l] = ((^data_s2_q[LO +: BCF_LANE_W]) == odd_s2_q);
        assign gen_word[LO +: BCF_LANE_W - 1] = sel_word[LO +: BCF_LANE_W - 1];
        assign gen_word[LO + BCF_LANE_W - 1] = ctl_s2_q[BCF_C_PGEN] ?
          ((^sel_word[LO +: BCF_LANE_W - 1]) ^ odd_s2_q) : sel_word[LO + BCF_LANE_W - 1];
      end
      // Check trees are shared with mailbox generation, so the check is masked then
      assign gen_on_mail = ~ctl_s2_q[BCF_C_WRITE] & ctl_s2_q[BCF_C_MBOX] & ctl_s2_q[BCF_C_PGEN];

      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          dout_q <= BCF_WORD_RST;
          oe_q <= 1'b0;
          perr_n_q <= 1'b1;
        end else begin
          dout_q <= gen_word;
          oe_q <= ~ctl_s2_q[BCF_C_SEL_N] & ~ctl_s2_q[BCF_C_WRITE];
          perr_n_q <= (&lane_ok) | gen_on_mail;
        end
      end
      assign out_data[p] = dout_q;
      assign drive[p] = oe_q;
      assign perr_n[p] = perr_n_q;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Stores, store s is written by port s and read by the other
  // ---------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_store
      bcf_store u_store (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_wr_tick(tick[s]),
        .i_wr_req(wr_fifo[s]),
        .i_wr_data(in_word[s]),
        .i_rd_tick(tick[1-s]),
        .i_rd_req(rd_fifo[1-s]),
        .o_rd_data(st_rd_data[s]),
        .i_offset(offset_q),
        .o_empty_n(st_empty_n[s]),
        .o_almost_empty_n(st_aempty_n[s]),
        .o_full_n(st_full_n[s]),
        .o_almost_full_n(st_afull_n[s])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs, all taken from flip-flops
  // ---------------------------------------------------------------
  assign o_port_a_data_bus = out_data[0];
  assign o_port_a_data_bus_oe = drive[0];
  // port A empty from B-to-A store
  assign o_port_a_empty_n = st_empty_n[1];
  assign o_port_a_almost_empty_n = st_aempty_n[1];
  assign o_port_a_full_n = st_full_n[0];
  assign o_port_a_almost_full_n = st_afull_n[0];
  assign o_port_a_parity_error_n = perr_n[0];
  assign o_mail_ab_pending_n = mail_flag[0];
  assign o_port_b_data_bus = out_data[1];
  assign o_port_b_data_bus_oe = drive[1];
  // port B empty from A-to-B store
  // port B empty and full flags, plain and almost, step on port B rises
  assign o_port_b_empty_n = st_empty_n[0];
  assign o_port_b_almost_empty_n = st_aempty_n[0];
  assign o_port_b_full_n = st_full_n[1];
  assign o_port_b_almost_full_n = st_afull_n[1];
  assign o_port_b_parity_error_n = perr_n[1];
  assign o_mail_ba_pending_n = mail_flag[1];
endmodule : bcf_mailbox_fifo
`default_nettype wire

// File: hdl/bcf_store.sv
`timescale 1ns/100ps
`default_nettype none
module bcf_store
  import bcf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Write side
  input wire logic i_wr_tick,
  input wire logic i_wr_req,
  input wire bcf_word_t i_wr_data,
  // Read side
  input wire logic i_rd_tick,
  input wire logic i_rd_req,
  output bcf_word_t o_rd_data,
  // Flag control and flags
  input wire bcf_count_t i_offset,
  output logic o_empty_n,
  output logic o_almost_empty_n,
  output logic o_full_n,
  output logic o_almost_full_n
);
  // ---------------------------------------------------------------
  // Storage and occupancy
  // ---------------------------------------------------------------
  bcf_word_t mem_q [BCF_DEPTH];
  logic [BCF_PTR_W-1:0] wr_ptr_q;
  logic [BCF_PTR_W-1:0] rd_ptr_q;
  bcf_count_t count_q;
  bcf_count_t count_d;
  bcf_count_t free_cnt;
  logic empty_s1_q;
  logic aempty_s1_q;
  logic full_s1_q;
  logic afull_s1_q;
  wire logic wr_go;
  wire logic rd_go;
  wire logic raw_empty_n;
  wire logic raw_full_n;
  wire logic raw_aempty_n;
  wire logic raw_afull_n;

  // full blocks writes
  // Raw count also guards, since the flag lags two port edges behind
  assign wr_go = i_wr_req & o_full_n & (count_q != BCF_DEPTH_CNT);
  assign rd_go = i_rd_req & o_empty_n & (count_q != 7'h00);
  assign count_d = count_q + {6'h00, wr_go} - {6'h00, rd_go};
  assign free_cnt = BCF_DEPTH_CNT - count_q;
  assign raw_empty_n = (count_q != 7'h00);
  assign raw_full_n = (count_q != BCF_DEPTH_CNT);
  assign raw_aempty_n = (count_q > i_offset);
  assign raw_afull_n = (free_cnt > i_offset);

  always_ff @(posedge i_clk) begin
    if (wr_go) begin
      mem_q[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= 7'h00;
      o_rd_data <= BCF_WORD_RST;
    end else begin
      count_q <= count_d;
      if (wr_go) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
      if (rd_go) begin
        rd_ptr_q <= rd_ptr_q + 6'h01;
        o_rd_data <= mem_q[rd_ptr_q];
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag stages
  // ---------------------------------------------------------------
  // full flags on writing port
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      full_s1_q <= BCF_FLAG_RST;
      o_full_n <= BCF_FLAG_RST;
      afull_s1_q <= BCF_FLAG_RST;
      o_almost_full_n <= BCF_FLAG_RST;
    end else if (i_wr_tick) begin
      full_s1_q <= raw_full_n;
      o_full_n <= full_s1_q;
      afull_s1_q <= raw_afull_n;
      o_almost_full_n <= afull_s1_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      empty_s1_q <= BCF_FLAG_RST;
      o_empty_n <= BCF_FLAG_RST;
      aempty_s1_q <= BCF_FLAG_RST;
      o_almost_empty_n <= BCF_FLAG_RST;
    end else if (i_rd_tick) begin
      empty_s1_q <= raw_empty_n;
      o_empty_n <= empty_s1_q;
      aempty_s1_q <= raw_aempty_n;
      o_almost_empty_n <= aempty_s1_q;
    end
  end
endmodule : bcf_store
`default_nettype wire

// File: inc/bcf_pkg.sv
// Operation
// - Two 64x36 stores carry words A to B and B to A.
// - Two 36-bit mailboxes bypass the stores, each with a new-mail flag.
// - Parity checked passively on inputs; parity generation on reads selectable per port.
// - Transfers happen only on a port clock rise with that port's enables asserted.
// - Port clocks are independent, possibly asynchronous or coincident, and free running.
// - Full and almost-full pass two stages on the writing port's clock.
// - Empty and almost-empty pass two stages on the reading port's clock.
// - Almost-empty low when reading store count is at or below the offset.
// - Almost-full low when writing store free space is at or below the offset.
// - Each port has a 36-bit two-way data bus, input on writes, output on reads.
// - Data bus outputs float while that port's chip select is high.
// - Port A empty low means B-to-A store empty and reads blocked.
// - Port A empty low at reset, rises second port A edge after first word.
// - Port B empty low at reset, blocks reads, rises second port B edge after word.
// - Port B empty, almost-empty, full and almost-full flags change only on port B clock rises.
// - Port A full low at reset, rises second port A edge after; blocks writes.
// - Offset select inputs are captured at reset release, picking one of four presets.
// - Mailbox select high routes the port's read or write to a mailbox.
package bcf_pkg;
  localparam int BCF_DEPTH = 64;
  localparam int BCF_WIDTH = 36;
  localparam int BCF_PTR_W = 6;
  localparam int BCF_CNT_W = 7;
  localparam int BCF_LANES = 4;
  localparam int BCF_LANE_W = 9;
  localparam logic [6:0] BCF_DEPTH_CNT = 7'h40;
  // Preset offsets picked by the two offset select inputs
  localparam logic [3:0][6:0] BCF_OFFSET_PRESETS = {7'h04, 7'h08, 7'h0c, 7'h10};
  localparam logic [6:0] BCF_OFFSET_RST = 7'h10;
  localparam logic BCF_FLAG_RST = 1'b0;
  localparam logic BCF_MAIL_FLAG_RST = 1'b1;
  localparam logic [35:0] BCF_WORD_RST = 36'h0;
  // Control pin vector positions after synchronising
  localparam int BCF_C_CLK = 0;
  localparam int BCF_C_SEL_N = 1;
  localparam int BCF_C_QUAL = 2;
  localparam int BCF_C_WRITE = 3;
  localparam int BCF_C_MBOX = 4;
  localparam int BCF_C_PGEN = 5;
  localparam int BCF_C_W = 6;
  typedef logic [35:0] bcf_word_t;
  typedef logic [6:0] bcf_count_t;
endpackage : bcf_pkg

// File: sim/bcf_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bcf_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Port A
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_qualify,
  input wire logic i_port_a_write,
  input wire logic i_port_a_mailbox_select,
  input wire logic o_port_a_data_bus_oe,
  input wire logic o_port_a_empty_n,
  input wire logic o_port_a_full_n,
  input wire logic o_mail_ba_pending_n,
  // Port B
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  input wire logic o_port_b_data_bus_oe,
  input wire logic o_port_b_empty_n,
  input wire logic o_port_b_almost_empty_n,
  input wire logic o_port_b_full_n,
  input wire logic o_port_b_almost_full_n,
  input wire logic o_mail_ab_pending_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Cycles since the port B clock rose; flags may only move just after it
  logic [2:0] since_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      since_q <= 3'h7;
    end else if ($rose(i_port_b_clock)) begin
      since_q <= 3'h0;
    end else if (since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  property p_a_float;
    i_port_a_select_n [*4] |-> !o_port_a_data_bus_oe;
  endproperty
  a_a_float: assert property (p_a_float) else $error("port a bus driven while deselected");
  property p_b_float;
    i_port_b_select_n [*4] |-> !o_port_b_data_bus_oe;
  endproperty
  a_b_float: assert property (p_b_float) else $error("port b bus driven while deselected");
  property p_a_drive;
    $rose(o_port_a_data_bus_oe) |-> $past(!i_port_a_select_n && !i_port_a_write, 3);
  endproperty
  a_a_drive: assert property (p_a_drive) else $error("port a bus driven without a read");
  property p_ab_mail;
    $fell(o_mail_ab_pending_n) |->
      $past(!i_port_a_select_n && i_port_a_qualify && i_port_a_write && i_port_a_mailbox_select, 3);
  endproperty
  a_ab_mail: assert property (p_ab_mail) else $error("mail flag set without a mailbox write");
  property p_ba_read;
    $rose(o_mail_ba_pending_n) |->
      $past(!i_port_a_select_n && i_port_a_qualify && !i_port_a_write && i_port_a_mailbox_select, 3);
  endproperty
  a_ba_read: assert property (p_ba_read) else $error("mail flag cleared without a mailbox read");
  property p_full_rst;
    $rose(i_nrst) |-> !o_port_a_full_n [*4] ##[1:40] o_port_a_full_n;
  endproperty
  a_full_rst: assert property (p_full_rst) else $error("port a full flag wrong after reset");
  property p_empty_rst;
    $rose(i_nrst) |-> !o_port_a_empty_n && !o_port_b_empty_n && o_mail_ab_pending_n;
  endproperty
  a_empty_rst: assert property (p_empty_rst) else $error("flags wrong at reset release");
  property p_b_flags;
    $changed({o_port_b_empty_n, o_port_b_almost_empty_n, o_port_b_full_n, o_port_b_almost_full_n})
      |-> since_q inside {[3'h1:3'h3]};
  endproperty
  a_b_flags: assert property (p_b_flags) else $error("port b flag moved off its clock");
endmodule : bcf_chk
bind bcf_mailbox_fifo bcf_chk u_chk (.*);
`default_nettype wire

// File: sim/bcf_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module bcf_port_model
  import bcf_pkg::*;
#(
  parameter logic [2:0] PHASE = 3'h0
) (
  // Clock
  input wire logic i_clk,
  // Device side of the pins
  input wire bcf_word_t i_dev_data,
  input wire logic i_dev_oe,
  // Pins driven by this party
  output logic o_clock,
  output logic o_select_n,
  output logic o_qualify,
  output logic o_write,
  output logic o_mailbox_select,
  output bcf_word_t o_data
);
  logic [2:0] cnt_q = PHASE;
  bcf_word_t drv = 36'h0;
  always @(negedge i_clk) cnt_q <= cnt_q + 3'h1;
  assign o_clock = cnt_q[2];
  // Released bus shows the inverse of the last word, never a stale copy
  assign o_data = i_dev_oe ? i_dev_data : drv;
  initial begin
    o_select_n = 1'b1;
    o_qualify = 1'b0;
    o_write = 1'b0;
    o_mailbox_select = 1'b0;
  end
  task automatic op(input logic wr, input logic mb, input logic qual, input bcf_word_t wd, output bcf_word_t rd);
    @(negedge i_clk iff cnt_q == 3'h0);
    o_select_n = 1'b0;
    o_qualify = qual;
    o_write = wr;
    o_mailbox_select = mb;
    drv = wd;
    @(negedge i_clk iff cnt_q == 3'h0);
    rd = o_data;
    o_select_n = 1'b1;
    o_qualify = 1'b0;
    drv = ~wd;
  endtask : op
endmodule : bcf_port_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bcf_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pga = 1'b0;
  logic pgb = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  bcf_word_t rd;
  wire logic ack, asn, aq, aw, am, aoe, aef, aae, aff, aaf, mab;
  wire logic bck, bsn, bq, bw, bm, boe, bef, bae, bff, baf, port_a_mailbox_select;
  wire logic pea, peb;
  wire bcf_word_t ain, aout, bin, bout;
  always #25 clk = ~clk;
  bcf_mailbox_fifo u_dut (.i_clk(clk), .i_nrst(nrst), .i_odd_parity(1'b0), .i_offset_preset_select(2'h0),
    .i_port_a_clock(ack), .i_port_a_select_n(asn), .i_port_a_qualify(aq), .i_port_a_write(aw),
    .i_port_a_mailbox_select(am), .i_port_a_parity_gen(pga), .i_port_a_data_bus(ain),
    .o_port_a_data_bus(aout), .o_port_a_data_bus_oe(aoe), .o_port_a_empty_n(aef),
    .o_port_a_almost_empty_n(aae), .o_port_a_full_n(aff), .o_port_a_almost_full_n(aaf),
    .o_port_a_parity_error_n(pea), .o_mail_ab_pending_n(mab),
    .i_port_b_clock(bck), .i_port_b_select_n(bsn), .i_port_b_qualify(bq), .i_port_b_write(bw),
    .i_port_b_mailbox_select(bm), .i_port_b_parity_gen(pgb), .i_port_b_data_bus(bin),
    .o_port_b_data_bus(bout), .o_port_b_data_bus_oe(boe), .o_port_b_empty_n(bef),
    .o_port_b_almost_empty_n(bae), .o_port_b_full_n(bff), .o_port_b_almost_full_n(baf),
    .o_port_b_parity_error_n(peb), .o_mail_ba_pending_n(port_a_mailbox_select));
  bcf_port_model #(.PHASE(3'h0)) u_pa (.i_clk(clk), .i_dev_data(aout), .i_dev_oe(aoe), .o_clock(ack),
    .o_select_n(asn), .o_qualify(aq), .o_write(aw), .o_mailbox_select(am), .o_data(ain));
  bcf_port_model #(.PHASE(3'h3)) u_pb (.i_clk(clk), .i_dev_data(bout), .i_dev_oe(boe), .o_clock(bck),
    .o_select_n(bsn), .o_qualify(bq), .o_write(bw), .o_mailbox_select(bm), .o_data(bin));
  function automatic bcf_word_t gen_par(input bcf_word_t w);
    bcf_word_t r;
    r = w;
    for (int l = 0; l < 4; l++) r[9*l+8] = ^w[9*l +: 8];
    return r;
  endfunction : gen_par
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  task automatic chk_w(input bcf_word_t got, input bcf_word_t exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic t_reset;
    chk_b(aef, 1'b0);
    chk_b(bef, 1'b0);
    chk_b(mab, 1'b1);
    wait_cyc(40);
    chk_b(aff, 1'b1);
    $display("test reset done");
  endtask : t_reset
  // Middle write has its enable low and must leave no trace
  task automatic t_ab;
    u_pa.op(1'b1, 1'b0, 1'b1, 36'h1_0000_0001, rd);
    u_pa.op(1'b1, 1'b0, 1'b0, 36'h2_0000_0002, rd);
    u_pa.op(1'b1, 1'b0, 1'b1, 36'h3_0000_0003, rd);
    wait_cyc(24);
    chk_b(bef, 1'b1);
    u_pb.op(1'b0, 1'b0, 1'b1, 36'h0, rd);
    chk_w(rd, 36'h1_0000_0001);
    u_pb.op(1'b0, 1'b0, 1'b1, 36'h0, rd);
    chk_w(rd, 36'h3_0000_0003);
    wait_cyc(24);
    chk_b(bef, 1'b0);
    $display("test a_to_b done");
  endtask : t_ab
  // Offset preset 0 gives 16; the 65th write hits a full store
  task automatic t_fill;
    for (int i = 1; i <= 65; i++) begin
      u_pb.op(1'b1, 1'b0, 1'b1, {4'h5, 32'(i)}, rd);
      if (i == 16 || i == 17) begin
        wait_cyc(24);
        chk_b(aae, i == 17);
      end
      if (i == 47 || i == 48) begin
        wait_cyc(24);
        chk_b(baf, i == 47);
      end
    end
    chk_b(bff, 1'b0);
    for (int i = 1; i <= 64; i++) begin
      u_pa.op(1'b0, 1'b0, 1'b1, 36'h0, rd);
      chk_w(rd, {4'h5, 32'(i)});
    end
    wait_cyc(24);
    chk_b(aef, 1'b0);
    $display("test fill done");
  endtask : t_fill
  task automatic t_mail;
    u_pa.op(1'b1, 1'b1, 1'b1, 36'h1_2345_6789, rd);
    chk_b(mab, 1'b0);
    u_pa.op(1'b1, 1'b1, 1'b1, 36'hf_0f0f_0f0f, rd);
    pgb = 1'b1;
    u_pb.op(1'b0, 1'b1, 1'b1, 36'h0, rd);
    chk_w(rd, gen_par(36'h1_2345_6789));
    chk_b(mab, 1'b1);
    pgb = 1'b0;
    u_pb.op(1'b1, 1'b1, 1'b1, 36'h9_8765_4321, rd);
    u_pa.op(1'b0, 1'b1, 1'b1, 36'h0, rd);
    chk_w(rd, 36'h9_8765_4321);
    $display("test mailbox done");
  endtask : t_mail
  // Enable held low so the bus words are only checked, never stored
  task automatic t_parity;
    u_pa.op(1'b1, 1'b0, 1'b0, 36'h0, rd);
    chk_b(pea, 1'b1);
    u_pa.op(1'b1, 1'b0, 1'b0, 36'h0_0000_0001, rd);
    chk_b(pea, 1'b0);
    u_pb.op(1'b1, 1'b0, 1'b0, 36'h0, rd);
    chk_b(peb, 1'b1);
    u_pb.op(1'b1, 1'b0, 1'b0, 36'h8_0000_0000, rd);
    chk_b(peb, 1'b0);
    $display("test parity done");
  endtask : t_parity
  initial begin
    wait_cyc(20);
    nrst = 1'b1;
    t_reset;
    t_ab;
    t_fill;
    t_mail;
    t_parity;
    conclude;
  end
  // Tests need about 2500 cycles; allow several times that
  initial begin
    wait_cyc(20000);
    miscompares++;
    conclude;
  end
endmodule : tb
`default_nettype wire
